// >>> ppo_pkg.sv
// Behaviour
// - In power-down, power-save or standby sleep, clamp pin digital input to ground.
// - Clamp is skipped for pins whose external interrupt request is enabled.
// - Disabled edge interrupt pin held high through clamp flags a change on wake.
// - All pull-ups stay off while reset is active.
// - Pull-up override enable makes pull-up follow override value while the pin driver is off.
// - Without override, pull-up on only when direction, latch, global-off equal 010.
// - Drive override enable selects driver from override value, else direction bit.
// - Driven pin takes value override when enabled, otherwise the output latch.
// - Toggle override enable inverts the pin output latch bit.
// - Input-enable override sets digital input enable, else sleep state decides.
// - Alternate modules get unsynchronised post-trigger input and synchronise it themselves.
// - Global pull-up off bit 6 of mcu_control disables every pull-up without pull-up override enable.
// - Register strobes per port; clock, clamp, global-off common; overrides per pin.
// - Direction bit one means output; it drives the driver without override.
package ppo_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] PPO_ADDR_MCU_CONTROL = 4'h0;
  localparam logic [3:0] PPO_ADDR_DIRECTION = 4'h1;
  localparam logic [3:0] PPO_ADDR_OUT_LATCH = 4'h2;
  localparam logic [3:0] PPO_ADDR_PIN_TOGGLE = 4'h3;
  localparam logic [3:0] PPO_ADDR_PIN_INPUT = 4'h4;
  localparam logic [3:0] PPO_ADDR_IRQ_STATUS = 4'h5;
  localparam logic [3:0] PPO_ADDR_IRQ_MASK = 4'h6;
  localparam logic [3:0] PPO_ADDR_EXT_IRQ_EN = 4'h7;
  localparam logic [3:0] PPO_ADDR_SLEEP_MODE = 4'h8;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int PPO_PULLUP_GLOBAL_OFF_BIT = 6;
  localparam logic [7:0] PPO_MCU_CONTROL_RESET = 8'h00;
  localparam logic [2:0] PPO_PULLUP_PATTERN = 3'b010;
  localparam logic [31:0] PPO_UNMAPPED_READ = 32'h0000_0000;
  // Sleep states of the sleep controller
  typedef enum logic [2:0] {
    PPO_SLP_ACTIVE,
    PPO_SLP_IDLE,
    PPO_SLP_ADC_NR,
    PPO_SLP_POWER_DOWN,
    PPO_SLP_POWER_SAVE,
    PPO_SLP_STANDBY
  } ppo_sleep_t;
endpackage

// >>> ppo_port.sv
`timescale 1ns/1ps
module ppo_port #(
  parameter int N = 6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  // Per-pin overrides from peripheral modules
  input wire logic [N-1:0] pullup_override_enable,
  input wire logic [N-1:0] pullup_override_value,
  input wire logic [N-1:0] drive_override_enable,
  input wire logic [N-1:0] drive_override_value,
  input wire logic [N-1:0] pin_value_override_enable,
  input wire logic [N-1:0] pin_value_override_value,
  input wire logic [N-1:0] port_toggle_override_enable,
  input wire logic [N-1:0] input_enable_override_enable,
  input wire logic [N-1:0] input_enable_override_value,
  output logic [N-1:0] alt_func_raw_input,
  // Pad side
  input wire logic [N-1:0] pad_in,
  output logic [N-1:0] pad_out,
  output logic [N-1:0] pad_oe,
  output logic [N-1:0] pad_pullup
);
  import ppo_pkg::*;

  typedef struct packed {
    logic [7:0] mcu_control;
    logic [N-1:0] pin_output_select;
    logic [N-1:0] pin_out_latch;
    logic [N-1:0] ext_irq_en;
    logic [N-1:0] irq_status;
    logic [N-1:0] irq_mask;
    logic [2:0] sleep_mode;
    logic [N-1:0] raw_q;
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] sync_prev;
    logic [N-1:0] pad_out;
    logic [N-1:0] pad_oe;
    logic [N-1:0] pad_pullup;
    logic [N-1:0] alt_raw;
    logic [31:0] readdata;
    logic ack;
    logic irq;
  } ppo_state_t;

  ppo_state_t st;
  ppo_state_t next_st;
  logic clamp_mode;
  logic [N-1:0] din_enable;
  logic [N-1:0] drv_en;
  logic [N-1:0] drv_val;
  logic [N-1:0] pu_en;
  logic [N-1:0] gated_in;
  logic [N-1:0] eff_latch;
  logic pullup_off;

  // ----------------------------------------------------------------
  // Pin override logic
  // ----------------------------------------------------------------
  // Sleep clamp is one signal common to every pin of the port
  assign clamp_mode = (st.sleep_mode == 3'(PPO_SLP_POWER_DOWN)) ||
                      (st.sleep_mode == 3'(PPO_SLP_POWER_SAVE)) ||
                      (st.sleep_mode == 3'(PPO_SLP_STANDBY));
  assign pullup_off = st.mcu_control[PPO_PULLUP_GLOBAL_OFF_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_pin
      // Toggle override flips the latch seen by the driver
      assign eff_latch[gi] = st.pin_out_latch[gi] ^ port_toggle_override_enable[gi];
      // Direction bit is the default driver source
      assign drv_en[gi] = drive_override_enable[gi] ? drive_override_value[gi]
                                                     : st.pin_output_select[gi];
      assign drv_val[gi] = pin_value_override_enable[gi] ? pin_value_override_value[gi]
                                                         : eff_latch[gi];
      assign pu_en[gi] = pullup_override_enable[gi] ? pullup_override_value[gi]
        : ({st.pin_output_select[gi], eff_latch[gi], pullup_off}
           == PPO_PULLUP_PATTERN);
      // Enabled external interrupt keeps the input alive in deep sleep
      assign din_enable[gi] = input_enable_override_enable[gi]
        ? input_enable_override_value[gi]
        : (!clamp_mode || st.ext_irq_en[gi]);
      assign gated_in[gi] = st.sync2[gi] & din_enable[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Synchronised copy is modelled here; modules get the unsynchronised copy
  always_comb begin
    logic [N-1:0] wmask;
    logic [N-1:0] wbits;
    logic [N-1:0] event_set;
    wmask = '0;
    wbits = avs_writedata[N-1:0];
    event_set = '0;
    next_st = st;
    next_st.sync1 = pad_in;
    next_st.sync2 = st.sync1;
    next_st.raw_q = pad_in;
    next_st.alt_raw = st.raw_q & din_enable;
    next_st.sync_prev = gated_in;
    // Clamp release of a high pin shows as a change and is flagged
    event_set = gated_in ^ st.sync_prev;
    next_st.pad_oe = drv_en;
    next_st.pad_out = drv_val & drv_en;
    next_st.pad_pullup = pu_en & ~drv_en;
    next_st.ack = 1'b0;
    next_st.readdata = PPO_UNMAPPED_READ;
    if ((avs_read || avs_write) && !st.ack) begin
      next_st.ack = 1'b1;
    end
    // A write lands only at the edge that shows waitrequest low to the master
    if (avs_write && st.ack && avs_byteenable[0]) begin
      wmask = wbits;
      case (avs_address)
        PPO_ADDR_MCU_CONTROL: next_st.mcu_control = avs_writedata[7:0];
        PPO_ADDR_DIRECTION: next_st.pin_output_select = wbits;
        PPO_ADDR_OUT_LATCH: next_st.pin_out_latch = wbits;
        PPO_ADDR_PIN_TOGGLE: next_st.pin_out_latch = st.pin_out_latch ^ wbits;
        PPO_ADDR_IRQ_MASK: next_st.irq_mask = wbits;
        PPO_ADDR_EXT_IRQ_EN: next_st.ext_irq_en = wbits;
        PPO_ADDR_SLEEP_MODE: next_st.sleep_mode = avs_writedata[2:0];
        default: ;
      endcase
    end
    // Set wins over the write-one clear
    if (avs_write && st.ack && avs_byteenable[0] && avs_address == PPO_ADDR_IRQ_STATUS) begin
      next_st.irq_status = (st.irq_status & ~wmask) | event_set;
    end else begin
      next_st.irq_status = st.irq_status | event_set;
    end
    if (avs_read && !st.ack) begin
      case (avs_address)
        PPO_ADDR_MCU_CONTROL: next_st.readdata = {24'h00_0000, st.mcu_control};
        PPO_ADDR_DIRECTION: next_st.readdata = 32'(st.pin_output_select);
        PPO_ADDR_OUT_LATCH: next_st.readdata = 32'(st.pin_out_latch);
        PPO_ADDR_PIN_INPUT: next_st.readdata = 32'(gated_in);
        PPO_ADDR_IRQ_STATUS: next_st.readdata = 32'(st.irq_status);
        PPO_ADDR_IRQ_MASK: next_st.readdata = 32'(st.irq_mask);
        PPO_ADDR_EXT_IRQ_EN: next_st.readdata = 32'(st.ext_irq_en);
        PPO_ADDR_SLEEP_MODE: next_st.readdata = {29'h0000_0000, st.sleep_mode};
        default: next_st.readdata = PPO_UNMAPPED_READ;
      endcase
    end
    next_st.irq = |(next_st.irq_status & st.irq_mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset clears pull-up enables and tri-states the pads
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.mcu_control <= PPO_MCU_CONTROL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops; the async reset already clears the pull-ups
  assign pad_pullup = st.pad_pullup;
  assign pad_out = st.pad_out;
  assign pad_oe = st.pad_oe;
  assign alt_func_raw_input = st.alt_raw;
  assign avs_readdata = st.readdata;
  assign avs_waitrequest = !st.ack;
  assign irq = st.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_pullup_override: assert property (@(posedge core_clk) disable iff (!rst_n)
    pullup_override_enable[0] && !drv_en[0] |=> pad_pullup[0] == $past(pullup_override_value[0]))
    else $error("pull-up does not follow override");
  a_global_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    pullup_off && !pullup_override_enable[0] |=> !pad_pullup[0])
    else $error("global off left pull-up on");
  a_drive_dir: assert property (@(posedge core_clk) disable iff (!rst_n)
    !drive_override_enable[0] |=> pad_oe[0] == $past(st.pin_output_select[0]))
    else $error("driver not from direction");
  a_value_ovr: assert property (@(posedge core_clk) disable iff (!rst_n)
    drv_en[0] && pin_value_override_enable[0] |=> pad_out[0] == $past(pin_value_override_value[0]))
    else $error("pin value override ignored");
  a_toggle_ovr: assert property (@(posedge core_clk) disable iff (!rst_n)
    drv_en[0] && !pin_value_override_enable[0] && port_toggle_override_enable[0]
    |=> pad_out[0] == !$past(st.pin_out_latch[0]))
    else $error("toggle override ignored");
  a_sleep_clamp: assert property (@(posedge core_clk) disable iff (!rst_n)
    clamp_mode && !st.ext_irq_en[0] && !input_enable_override_enable[0] |-> !gated_in[0])
    else $error("input not clamped in sleep");
  a_irq_keeps: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.ext_irq_en[0] && !input_enable_override_enable[0] |-> din_enable[0])
    else $error("interrupt pin clamped");
  a_die_ovr: assert property (@(posedge core_clk) disable iff (!rst_n)
    input_enable_override_enable[0] |-> din_enable[0] == input_enable_override_value[0])
    else $error("input enable override ignored");
  a_wake_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    gated_in[0] && !st.sync_prev[0] |=> st.irq_status[0])
    else $error("change not flagged");
  a_bus_ack: assert property (@(posedge core_clk) disable iff (!rst_n)
    avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  // ----------------------------------------------------------------
  // Further pin and bus checks
  // ----------------------------------------------------------------
  // Pull-ups stay off for as long as reset is held
  a_reset_pullup: assert property (@(posedge core_clk)
    !rst_n |-> pad_pullup == '0)
    else $error("pull-up on during reset");

  // Plain pull-up follows the direction, latch and global-off pattern
  a_pullup_pattern: assert property (@(posedge core_clk) disable iff (!rst_n)
    !pullup_override_enable[0] && !drv_en[0] |=> pad_pullup[0] ==
    $past({st.pin_output_select[0], eff_latch[0], pullup_off} == PPO_PULLUP_PATTERN))
    else $error("pull-up pattern wrong");

  // Drive override value decides the driver
  a_drive_ovr: assert property (@(posedge core_clk) disable iff (!rst_n)
    drive_override_enable[0] |=> pad_oe[0] == $past(drive_override_value[0]))
    else $error("drive override ignored");

  // Direction one turns the driver on without override
  a_oe_on_dir: assert property (@(posedge core_clk) disable iff (!rst_n)
    !drive_override_enable[0] && st.pin_output_select[0] |=> pad_oe[0])
    else $error("output select ignored");

  // Without value or toggle override the latch reaches the pin
  a_value_latch: assert property (@(posedge core_clk) disable iff (!rst_n)
    drv_en[0] && !pin_value_override_enable[0] && !port_toggle_override_enable[0]
    |=> pad_out[0] == $past(st.pin_out_latch[0]))
    else $error("latch not on pin");

  // An undriven pad shows a low data level, never a stale value
  a_driver_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    !drv_en[0] |=> !pad_out[0])
    else $error("data on undriven pad");

  // Pull-up never fights the driver
  a_pullup_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
    drv_en[0] |=> !pad_pullup[0])
    else $error("pull-up while driving");

  // Modules see the raw input while the input is enabled
  a_alt_input: assert property (@(posedge core_clk) disable iff (!rst_n)
    input_enable_override_enable[0] && input_enable_override_value[0]
    |=> alt_func_raw_input[0] == $past(st.raw_q[0]))
    else $error("raw input not passed");

  // Outside deep sleep the input stays enabled without override
  a_ie_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
    !input_enable_override_enable[0] && !clamp_mode |-> din_enable[0])
    else $error("input disabled when awake");

  // Global off reaches the last pin as well
  a_global_last: assert property (@(posedge core_clk) disable iff (!rst_n)
    pullup_off && !pullup_override_enable[N-1] |=> !pad_pullup[N-1])
    else $error("global off missed last pin");

  // Clamp is common to every pin, the last one too
  a_clamp_last: assert property (@(posedge core_clk) disable iff (!rst_n)
    clamp_mode && !st.ext_irq_en[N-1] && !input_enable_override_enable[N-1] |-> !gated_in[N-1])
    else $error("last pin not clamped");

  // Status bits stay set until written with one
  a_status_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.irq_status[0] && !(avs_write && st.ack && avs_address == PPO_ADDR_IRQ_STATUS)
    |=> st.irq_status[0])
    else $error("status bit lost");

  // Interrupt level tracks unmasked status
  a_irq_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    irq == ((st.irq_status & $past(st.irq_mask)) != '0))
    else $error("interrupt level wrong");

  // Mask changes only by a completed write
  a_mask_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(avs_write && !avs_waitrequest && avs_address == PPO_ADDR_IRQ_MASK)
    |=> $stable(st.irq_mask))
    else $error("mask changed without write");

  // Writes are answered one cycle after they are presented
  a_write_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
    avs_write && avs_waitrequest |=> !avs_waitrequest)
    else $error("write answer late");

  // Waitrequest is low for exactly one cycle per transfer
  a_ack_single: assert property (@(posedge core_clk) disable iff (!rst_n)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");

  // Unmapped reads return zero
  a_unmapped_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    avs_read && avs_waitrequest && avs_address > PPO_ADDR_SLEEP_MODE
    |=> avs_readdata == PPO_UNMAPPED_READ)
    else $error("unmapped read not zero");

  // Direction register reads back what it holds
  a_read_direction: assert property (@(posedge core_clk) disable iff (!rst_n)
    avs_read && avs_waitrequest && avs_address == PPO_ADDR_DIRECTION
    |=> avs_readdata == 32'($past(st.pin_output_select)))
    else $error("direction readback wrong");
endmodule

// >>> ppo_periph_model.sv
`timescale 1ns/1ps
// ------------------------------------------
// Peripheral side: drives every override pair
// ------------------------------------------
module ppo_periph_model #(
  parameter int N = 8
) (
  // Clock, reset and bench command
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [4:0] req_en,
  input wire logic [N-1:0] req_val,
  // Override outputs
  output logic [N-1:0] pue,
  output logic [N-1:0] puv,
  output logic [N-1:0] dde,
  output logic [N-1:0] ddv,
  output logic [N-1:0] pve,
  output logic [N-1:0] pvv,
  output logic [N-1:0] pte,
  output logic [N-1:0] iee,
  output logic [N-1:0] iev
);
  // Overrides made on core_clk, one pair per pin
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {pue, puv, dde, ddv, pve, pvv, pte, iee, iev} <= '0;
    end else begin
      pue <= {N{req_en[0]}};
      dde <= {N{req_en[1]}};
      pve <= {N{req_en[2]}};
      pte <= {N{req_en[3]}};
      iee <= {N{req_en[4]}};
      {puv, ddv, pvv, iev} <= {4{req_val}};
    end
  end
endmodule

// >>> port_pin_override_logic_tb_top.sv
`timescale 1ns/1ps
module port_pin_override_logic_tb_top;
  import ppo_pkg::*;
  logic core_clk = 0, rst_n = 0, rd_en = 0, wr_en = 0, wt, irq;
  logic [3:0] adr = '0;
  logic [31:0] wdat = '0, rdat;
  logic [4:0] req_en = '0;
  logic [7:0] req_val = '0, pad_in = '0, d;
  logic [7:0] pue, puv, dde, ddv, pve, pvv, pte, iee, iev, raw, pout, poe, ppu;
  int failures = 0, n_compared = 0, cyc = 0;
  always #12.5 core_clk = ~core_clk;
  ppo_periph_model #(.N(8)) pm (.core_clk(core_clk), .rst_n(rst_n), .req_en(req_en),
    .req_val(req_val), .pue(pue), .puv(puv), .dde(dde), .ddv(ddv), .pve(pve),
    .pvv(pvv), .pte(pte), .iee(iee), .iev(iev));
  ppo_port #(.N(8)) uut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(adr),
    .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdat), .avs_byteenable(4'hf),
    .avs_readdata(rdat), .avs_waitrequest(wt), .irq(irq),
    .pullup_override_enable(pue), .pullup_override_value(puv),
    .drive_override_enable(dde), .drive_override_value(ddv),
    .pin_value_override_enable(pve), .pin_value_override_value(pvv),
    .port_toggle_override_enable(pte), .input_enable_override_enable(iee),
    .input_enable_override_value(iev), .alt_func_raw_input(raw), .pad_in(pad_in),
    .pad_out(pout), .pad_oe(poe), .pad_pullup(ppu));
  // ------------------------------------------
  // Bus tasks and checks
  // ------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    adr <= a;
    wdat <= {24'h00_0000, v};
    wr_en <= 1;
    do @(posedge core_clk); while (wt !== 1'b0);
    wr_en <= 0;
    @(posedge core_clk);
  endtask
  // Read data is taken at the very edge that sees waitrequest low
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    adr <= a;
    rd_en <= 1;
    do @(posedge core_clk); while (wt !== 1'b0);
    v = rdat[7:0];
    rd_en <= 0;
    @(posedge core_clk);
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Margin covers the override model flop plus the pin path flops
  task automatic settle;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic finish_test;
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      finish_test();
    end
  end
  // ------------------------------------------
  // Main sequence
  // ------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    rd(PPO_ADDR_MCU_CONTROL, d);
    chk("mcu_control", PPO_MCU_CONTROL_RESET, d);
    rd(4'hf, d);
    chk("unmapped", 8'h00, d);
    for (int i = 0; i < 8; i++) begin
      wr(PPO_ADDR_DIRECTION, {8{i[2]}});
      wr(PPO_ADDR_OUT_LATCH, {8{i[1]}});
      wr(PPO_ADDR_MCU_CONTROL, {1'b0, i[0], 6'h00});
      settle();
      chk("pullup", {8{i == 2}}, ppu);
      chk("oe", {8{i[2]}}, poe);
      if (i[2]) chk("out", {8{i[1]}}, pout);
    end
    wr(PPO_ADDR_DIRECTION, 8'h00);
    req_en <= 5'b00001;
    req_val <= 8'hff;
    settle();
    chk("pu_ovr", 8'hff, ppu);
    wr(PPO_ADDR_MCU_CONTROL, 8'h00);
    req_en <= 5'b00110;
    settle();
    chk("drv_ovr", 8'hff, poe);
    chk("val_ovr", 8'hff, pout);
    req_val <= 8'h00;
    settle();
    chk("drv_off", 8'h00, poe);
    req_en <= 5'b00001;
    settle();
    chk("pu_ovr0", 8'h00, ppu);
    wr(PPO_ADDR_DIRECTION, 8'hff);
    wr(PPO_ADDR_OUT_LATCH, 8'haa);
    req_en <= 5'b01000;
    settle();
    chk("toggle", 8'h55, pout);
    wr(PPO_ADDR_PIN_TOGGLE, 8'h0f);
    rd(PPO_ADDR_OUT_LATCH, d);
    chk("latch_tgl", 8'ha5, d);
    // Sleep clamp, its exemption and the input-enable override
    req_en <= 5'b00000;
    wr(PPO_ADDR_DIRECTION, 8'h00);
    pad_in <= 8'hff;
    wr(PPO_ADDR_SLEEP_MODE, 8'h03);
    wr(PPO_ADDR_EXT_IRQ_EN, 8'h0f);
    settle();
    chk("clamp", 8'h0f, raw);
    rd(PPO_ADDR_PIN_INPUT, d);
    chk("pin_in", 8'h0f, d);
    req_en <= 5'b10000;
    req_val <= 8'hff;
    settle();
    chk("ie_ovr", 8'hff, raw);
    req_en <= 5'b00000;
    wr(PPO_ADDR_EXT_IRQ_EN, 8'h00);
    wr(PPO_ADDR_IRQ_MASK, 8'hff);
    settle();
    wr(PPO_ADDR_IRQ_STATUS, 8'hff);
    settle();
    chk("irq_idle", 8'h00, {7'h00, irq});
    wr(PPO_ADDR_SLEEP_MODE, 8'h00);
    settle();
    rd(PPO_ADDR_IRQ_STATUS, d);
    chk("wake_flag", 8'hff, d);
    chk("irq_up", 8'h01, {7'h00, irq});
    wr(PPO_ADDR_IRQ_MASK, 8'h00);
    settle();
    chk("irq_mask", 8'h00, {7'h00, irq});
    wr(PPO_ADDR_IRQ_STATUS, 8'hff);
    rd(PPO_ADDR_IRQ_STATUS, d);
    chk("w1c", 8'h00, d);
    req_en <= 5'b10000;
    req_val <= 8'h00;
    settle();
    chk("ie_off", 8'h00, raw);
    req_en <= 5'b00000;
    wr(PPO_ADDR_SLEEP_MODE, 8'h04);
    settle();
    rd(PPO_ADDR_PIN_INPUT, d);
    chk("psave_in", 8'h00, d);
    wr(PPO_ADDR_SLEEP_MODE, 8'h05);
    settle();
    rd(PPO_ADDR_PIN_INPUT, d);
    chk("stby_in", 8'h00, d);
    wr(PPO_ADDR_SLEEP_MODE, 8'h01);
    settle();
    rd(PPO_ADDR_PIN_INPUT, d);
    chk("idle_in", 8'hff, d);
    // Pull-ups drop as soon as reset is asserted
    req_en <= 5'b00000;
    wr(PPO_ADDR_OUT_LATCH, 8'hff);
    settle();
    rst_n <= 0;
    @(negedge core_clk);
    chk("rst_pu", 8'h00, ppu);
    finish_test();
  end
endmodule
